// ---- brg_defs.svh ----
// register offsets, field positions and reset values of the baud generator
`ifndef BRG_DEFS_SVH
`define BRG_DEFS_SVH
`define BRG_OFF_TX_CTRL   4'h0
`define BRG_OFF_RX_CTRL   4'h4
`define BRG_OFF_BAUD_CTRL 4'h8
`define BRG_OFF_DIV_HIGH  4'hc
`define BRG_OFF_STATUS    5'h10
`define BRG_BIT_MASTER    7
`define BRG_BIT_SYNC      4
`define BRG_BIT_HSPEED    2
`define BRG_BIT_WIDE      3
`define BRG_BIT_ENABLE    7
`define BRG_RST_TX_CTRL   8'h02
`define BRG_RST_RX_CTRL   8'h00
`define BRG_RST_BAUD_CTRL 8'h00
`define BRG_RST_DIV       8'h00
`define BRG_PRE_SLOW      6'h3f
`define BRG_PRE_MID       6'h0f
`define BRG_PRE_FAST      6'h03
`define BRG_OFF_DIV_LOW   5'h14
`endif

// ---- brg_pkg.sv ----
// types of the baud generator
package brg_pkg;
  typedef enum logic [1:0] {BRG_PRE_64, BRG_PRE_16, BRG_PRE_4} brg_pre_t;
  typedef enum {BRG_W_IDLE, BRG_W_RESP} brg_wstate_t;
endpackage

// ---- brg_top.sv ----
// baud rate generator with receive majority filter and axi4-lite registers
`timescale 1ns/10ps
`include "brg_defs.svh"
// Functional notes
// - The tick comes straight from the system clock, so the rate tracks that clock.
// - Each received bit level is the majority of two synchronized receive pin samples and the previous level.
// - Async, 8-bit, low speed gives clock over 64 times divisor plus one.
// - Async with exactly one of high speed or wide divider gives clock over 16 times n+1.
// - Sync mode gives clock over 4 times n+1 for both widths, ignoring high speed.
// - The divisor is the high byte concatenated above the low byte, unsigned.
// - The divisor is two separately writable byte registers.
// - With the wide divider clear only the low byte is used.
// - Writing either divisor byte clears the timer at once.
// - In sync mode the generated clock is used only as master, else the external clock.
module brg_top
  import brg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        receive_pin,
  input  wire logic        ext_clock_pin,
  output logic             bit_tick,
  output logic             sample_tick,
  output logic             rx_level,
  output logic             bit_clock
);

  // register state
  logic [7:0]  tx_ctrl_q, rx_ctrl_q, baud_ctrl_q, div_hi_q, div_lo_q;
  logic [15:0] timer_q;
  logic [5:0]  pre_q;
  logic        aw_q, w_q;
  logic [4:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [2:0]  rx_sync_q;
  logic [1:0]  ext_sync_q;
  logic        tick_q, sample_q, level_q, bclk_q;

  // write channel: address and data latched independently, any order
  wire         do_write = aw_q && w_q && !s_axi_bvalid;
  wire         wr_hit   = do_write && wstrb_q[0];
  wire         wr_tx    = wr_hit && awaddr_q == 5'(`BRG_OFF_TX_CTRL);
  wire         wr_rx    = wr_hit && awaddr_q == 5'(`BRG_OFF_RX_CTRL);
  wire         wr_baud  = wr_hit && awaddr_q == 5'(`BRG_OFF_BAUD_CTRL);
  wire         wr_dhi   = wr_hit && awaddr_q == 5'(`BRG_OFF_DIV_HIGH);
  wire         wr_dlo   = wr_hit && awaddr_q == `BRG_OFF_DIV_LOW;
  wire         wr_ok    = awaddr_q[4:2] <= 3'h5;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // mode decoding
  wire sync_mode = tx_ctrl_q[`BRG_BIT_SYNC];
  wire wide_divider_select = baud_ctrl_q[`BRG_BIT_WIDE];
  wire high_speed_select   = tx_ctrl_q[`BRG_BIT_HSPEED];
  wire clock_master_select = tx_ctrl_q[`BRG_BIT_MASTER];
  wire port_enable         = rx_ctrl_q[`BRG_BIT_ENABLE];
  // high byte ignored in 8-bit mode; pair is unsigned {high,low}
  wire [15:0] divisor = {wide_divider_select ? div_hi_q : 8'h00, div_lo_q};
  wire [5:0]  pre_last = pre_limit(sync_mode, wide_divider_select, high_speed_select);
  wire        timer_wrap = timer_q >= divisor;  // >= guards a divisor shrunk mid-count
  wire        pre_wrap   = pre_q >= pre_last;

  // prescaler end count from the mode bits
  function automatic logic [5:0] pre_limit(input logic s, input logic w, input logic h);
    brg_pre_t p;
    if (s)
      p = BRG_PRE_4;
    else if (w && h)
      p = BRG_PRE_4;
    else if (w ^ h)
      p = BRG_PRE_16;
    else
      p = BRG_PRE_64;
    case (p)
      BRG_PRE_4:  pre_limit = `BRG_PRE_FAST;
      BRG_PRE_16: pre_limit = `BRG_PRE_MID;
      default:    pre_limit = `BRG_PRE_SLOW;
    endcase
  endfunction

  // read mux; status word shows live timer and prescaler
  wire [31:0] rd_word =
    (s_axi_araddr[4:2] == 3'h0) ? {24'h0, tx_ctrl_q} :
    (s_axi_araddr[4:2] == 3'h1) ? {24'h0, rx_ctrl_q} :
    (s_axi_araddr[4:2] == 3'h2) ? {24'h0, baud_ctrl_q & 8'hfb} :
    (s_axi_araddr[4:2] == 3'h3) ? {24'h0, div_hi_q} :
    (s_axi_araddr[4:2] == 3'h4) ? {9'h0, rx_level, pre_q, timer_q} :
    (s_axi_araddr[4:2] == 3'h5) ? {24'h0, div_lo_q} : 32'h0;
  wire rd_ok = s_axi_araddr[4:2] <= 3'h5;

  // bus handshake state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;   // slverr on unmapped
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // control registers; status bit 1 of transmit control is held set here by reset and by every write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ctrl_q <= `BRG_RST_TX_CTRL;
      rx_ctrl_q <= `BRG_RST_RX_CTRL;
      baud_ctrl_q <= `BRG_RST_BAUD_CTRL;
      div_hi_q <= `BRG_RST_DIV;
      div_lo_q <= `BRG_RST_DIV;
    end else begin
      if (wr_tx) tx_ctrl_q <= wdata_q[7:0] | `BRG_RST_TX_CTRL;
      if (wr_rx) rx_ctrl_q <= wdata_q[7:0];
      if (wr_baud) baud_ctrl_q <= wdata_q[7:0] & 8'hfb;
      if (wr_dhi) div_hi_q <= wdata_q[7:0];
      if (wr_dlo) div_lo_q <= wdata_q[7:0];
    end
  end

  // free-running timer on the system clock, prescaled to the bit rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_q <= 16'h0;
      pre_q <= 6'h0;
      sample_q <= 1'b0;
      tick_q <= 1'b0;
    end else if (wr_dhi || wr_dlo || !port_enable) begin
      timer_q <= 16'h0;
      pre_q <= 6'h0;
      sample_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      timer_q <= timer_wrap ? 16'h0 : timer_q + 16'h1;
      sample_q <= timer_wrap;
      tick_q <= timer_wrap && pre_wrap;
      if (timer_wrap) pre_q <= pre_wrap ? 6'h0 : pre_q + 6'h1;
    end
  end

  // receive pin: two sync flops, then a third sample for majority
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sync_q <= 3'h7;
      ext_sync_q <= 2'h0;
      level_q <= 1'b1;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], receive_pin};
      ext_sync_q <= {ext_sync_q[0], ext_clock_pin};
      // majority of two synced samples and the held level, taken on the prescaler's sub-ticks
      if (sample_q)
        level_q <= (rx_sync_q[1] & rx_sync_q[2]) | (rx_sync_q[1] & level_q) |
                   (rx_sync_q[2] & level_q);
    end
  end

  // bit clock: toggle per tick as master, external pin as sync slave
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      bclk_q <= 1'b0;
    else if (sync_mode && !clock_master_select)
      bclk_q <= ext_sync_q[1];
    else if (tick_q)
      bclk_q <= !bclk_q;
  end

  assign bit_tick    = tick_q;
  assign sample_tick = sample_q;
  assign rx_level    = level_q;
  assign bit_clock   = bclk_q;

endmodule

// ---- brg_checker.sv ----
// checker of bus handshakes and tick timing
`timescale 1ns/10ps
module brg_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bit_tick,
  input wire logic sample_tick,
  input wire logic rx_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // shortest bit period is four clocks
  a_tick_spacing: assert property (bit_tick |=> !bit_tick [*3])
    else $error("bit ticks too close");
  // both items land on one edge, the write happens next cycle, the answer one later
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response open");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data open");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  // filtered level may only move at a timer wrap
  a_rx_on_wrap: assert property ($changed(rx_level) |-> sample_tick || $past(sample_tick))
    else $error("receive level moved off a wrap");
  c_tick: cover property (bit_tick);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_rx_low: cover property ($fell(rx_level));
endmodule

// ---- brg_partner.sv ----
// shift-logic model: measures clocks between ticks
`timescale 1ns/10ps
module brg_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic bit_tick,
  input wire logic sample_tick,
  output logic [15:0] bit_gap,
  output logic [15:0] wrap_gap
);
  logic [15:0] bit_cnt_q;
  logic [15:0] wrap_cnt_q;
  // gap counts the tick cycle itself, so it equals the period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= 16'h0;
      wrap_cnt_q <= 16'h0;
      bit_gap <= 16'h0;
      wrap_gap <= 16'h0;
    end else begin
      bit_cnt_q <= bit_tick ? 16'h1 : bit_cnt_q + 16'h1;
      wrap_cnt_q <= sample_tick ? 16'h1 : wrap_cnt_q + 16'h1;
      if (bit_tick) bit_gap <= bit_cnt_q;
      if (sample_tick) wrap_gap <= wrap_cnt_q;
    end
  end
endmodule

// ---- brg_tb_top.sv ----
// self-checking bench of the baud generator
`timescale 1ns/10ps
module brg_tb_top;
  logic clk, rst, receive_pin, ext_clock_pin, bit_tick, sample_tick, rx_level, bit_clock;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] gap_bit, gap_wrap;
  int bad_count, cmp_count;
  // modes as {sync, wide, high speed}; sync row 101 sets high speed to show it is ignored
  localparam logic [2:0] md_tab [6] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b101, 3'b110};
  brg_top u_dut (.*);
  brg_partner u_far (.clk, .rst, .bit_tick, .sample_tick, .bit_gap(gap_bit), .wrap_gap(gap_wrap));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int pre(input logic [2:0] m);
    return (m[2] || m == 3'b011) ? 4 : (m[1] || m[0]) ? 16 : 64;
  endfunction
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic stall();
    bad_count++;
    complete_run();
  endtask
  // address and data offered together, each dropped once taken
  // an edge passes first so a ready lowered by the last call is never raised in the same step
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int k;
    bit got;
    got = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50 && !got; k++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        got = 1'b1;
        chk({30'h0, s_axi_bresp}, 32'h0);
      end
    end
    if (!got) stall();
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] r);
    int k;
    bit got;
    got = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50 && !got; k++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        got = 1'b1;
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
      end
    end
    if (!got) stall();
  endtask
  // waits for c ticks of the bit (s=0) or the timer wrap (s=1)
  task automatic tk(input int c, input bit s);
    int k;
    for (k = 0; c > 0 && k < 40000; k++) begin
      @(posedge clk);
      if ((s ? sample_tick : bit_tick) === 1'b1) c--;
    end
    if (c > 0) stall();
    @(posedge clk);
  endtask
  initial begin
    int i, n;
    logic [2:0] m;
    logic [15:0] sd;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_clock_pin} = 43'h0;
    {rst, receive_pin, s_axi_wstrb} = 6'h31;
    sd = 16'hea10;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(5'h00, 32'h2, 2'b00);
    rd(5'h18, 32'h0, 2'b10);
    for (i = 0; i < 6; i++) begin
      m = md_tab[i];
      sd = lf(sd);
      @(posedge clk);
      wr(5'h04, 8'h00);
      wr(5'h00, {1'b1, 2'b00, m[2], 1'b0, m[0], 2'b00});
      wr(5'h08, {4'h0, m[1], 3'b000});
      wr(5'h0c, 8'h01);
      wr(5'h14, {4'h0, sd[3:0]});
      rd(5'h14, {28'h0, sd[3:0]}, 2'b00);
      wr(5'h04, 8'h80);
      n = m[1] ? 256 + sd[3:0] : sd[3:0];
      tk(3, 1'b0);
      chk(32'(gap_bit), 32'(pre(m) * (n + 1)));
      chk(32'(gap_wrap), 32'(n + 1));
    end
    receive_pin <= 1'b0;
    tk(3, 1'b1);
    chk({31'h0, rx_level}, 32'h0);
    receive_pin <= 1'b1;
    tk(3, 1'b1);
    receive_pin <= 1'b0;
    @(posedge clk);
    receive_pin <= 1'b1;
    tk(2, 1'b1);
    chk({31'h0, rx_level}, 32'h1);
    wr(5'h00, 8'h10);
    for (i = 0; i < 2; i++) begin
      ext_clock_pin <= ~i[0];
      repeat (6) @(posedge clk);
      chk({31'h0, bit_clock}, {31'h0, ~i[0]});
    end
    complete_run();
  end
endmodule
bind brg_top brg_checker u_chk (.clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .bit_tick(bit_tick), .sample_tick(sample_tick), .rx_level(rx_level));
